// ===== rtl/ultra_ctrl_consts.vh
`ifndef ULTRA_CTRL_CONSTS_VH
`define ULTRA_CTRL_CONSTS_VH
// Serial frame layout.
`define FRAME_BITS 16
`define CNT_W 5
`define ADDR_W 6
`define DATA_W 8
`define ADDR_MSB 14
`define ADDR_LSB 9
`define RW_BIT 15
// Status field positions in the response frame.
`define ST_SUPPLY_OK 5
`define ST_SHORT_BURST 4
`define ST_STUCK 3
`define ST_CRC 2
// Mode codes reported in status bits 1:0.
`define MODE_LISTEN 2'h0
`define MODE_BURST 2'h1
`define MODE_STANDBY 2'h2
`define MODE_SLEEP 2'h3
// Supply wait timeout.
`define SUPPLY_WAIT_MS 64
`define CLK_MHZ 100
// 64 ms at 100 MHz, sized to the wait counter.
`define SUPPLY_WAIT_CYCLES 23'd6400000
`define WAIT_CNT_W 23
`endif

// ===== rtl/serial_control_mode_status.v
`timescale 1ns/1ns
`include "ultra_ctrl_consts.vh"

module serial_control_mode_status #(
  parameter [22:0] SUPPLY_WAIT = `SUPPLY_WAIT_CYCLES
) (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Serial link pins.
  input wire chip_select_n,
  input wire sclk,
  input wire sdi,
  output reg sdo_o,
  output reg sdo_oe,
  // Received write, one-cycle pulse at frame end.
  output reg wr_strobe,
  output reg [5:0] wr_addr,
  output reg [7:0] wr_data,
  // Read data supplied by the register file for the addressed register.
  output reg [5:0] rd_addr,
  input wire [7:0] rd_data,
  // Mode control bits.
  input wire sleep_enable_bit,
  input wire standby_enable_bit,
  input wire supply_reg_enable,
  input wire burst_start,
  input wire burst_end,
  // Supply level comparator and fault flags.
  input wire drive_supply_ok_flag,
  input wire short_burst_fault,
  input wire stuck_drive_fault,
  input wire memory_crc_fault,
  // Analog block enables derived from the mode.
  output reg supply_reg_on,
  output reg analog_on,
  output reg tx_on,
  output reg rx_on,
  output reg [1:0] current_mode_code,
  // Echo and zero-cross outputs.
  input wire envelope_above_thr,
  input wire zero_cross_raw,
  input wire zero_cross_enable,
  input wire zero_cross_gate_by_echo,
  output reg echo_irq_out,
  output reg zero_cross_out
);

  localparam [4:0] ST_LISTEN = 5'h01;
  localparam [4:0] ST_BURST = 5'h02;
  localparam [4:0] ST_STANDBY = 5'h04;
  localparam [4:0] ST_SLEEP = 5'h08;
  localparam [4:0] ST_WAKE = 5'h10;
  // One-hot codes keep the decode to single bits. The wake state is the
  // extra step between sleep and the working modes; it is never reported
  // as a mode of its own, so the status field still shows one of four codes.

  // Three-stage synchronisers for pins; stage 1 only feeds stage 2.
  // The serial clock is sampled, not used as a clock, so the link must run
  // well below the system clock. With four to five cycles of latency per
  // edge, a serial half period under about 60 ns can lose bits.
  // Chip select resets to the idle level so that no false frame start is
  // seen when reset is released.
  reg [2:0] cs_sync_reg;
  reg [2:0] sck_sync_reg;
  reg [2:0] sdi_sync_reg;
  reg [2:0] env_sync_reg;
  reg cs_n_reg;
  reg sck_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      sdi_sync_reg <= 3'h0;
      env_sync_reg <= 3'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], chip_select_n};
      sck_sync_reg <= {sck_sync_reg[1:0], sclk};
      sdi_sync_reg <= {sdi_sync_reg[1:0], sdi};
      env_sync_reg <= {env_sync_reg[1:0], envelope_above_thr};
    end
  end

  // A change counts once stages two and three agree.
  // This filters one-cycle glitches on the pins at the cost of one more
  // cycle of delay; sdi skips this check but is taken from stage three, like the clock edges, so it stays aligned to its clock.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
    end else begin
      if (cs_sync_reg[1] == cs_sync_reg[2]) begin
        cs_n_reg <= cs_sync_reg[2];
      end
      if (sck_sync_reg[1] == sck_sync_reg[2]) begin
        sck_reg <= sck_sync_reg[2];
      end
    end
  end

  // An edge is seen when the agreed level differs from the last accepted one.
  // The edge flags are true in the same cycle in which the accepted level
  // updates, so each pin edge gives exactly one pulse.
  wire sck_rise = (sck_sync_reg[1] == sck_sync_reg[2]) && sck_sync_reg[2] && !sck_reg;
  wire sck_fall = (sck_sync_reg[1] == sck_sync_reg[2]) && !sck_sync_reg[2] && sck_reg;
  wire cs_active = !cs_n_reg;

  // Mode state machine.
  // Priority is sleep, then standby, then burst, then listen. Leaving sleep
  // always passes through the wake state, which holds until the drive supply
  // is ready, the regulator is switched off, or the timeout has run out.
  // The timeout counter only runs in the wake state, so a long stay in any
  // other mode cannot shorten the next wait.
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [22:0] wait_reg;
  // With the regulator off there is no level to wait for, so the wake state
  // passes at once. The comparator flag and the timeout each end the wait on
  // their own, whichever comes first.
  wire supply_ready = !supply_reg_enable || drive_supply_ok_flag ||
                      (wait_reg >= SUPPLY_WAIT);

  always @* begin
    // Holding the present state is the default on every path.
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP: begin
        if (!sleep_enable_bit) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (sleep_enable_bit) begin
          state_next = ST_SLEEP;
        end else if (supply_ready) begin
          state_next = standby_enable_bit ? ST_STANDBY : ST_LISTEN;
        end
      end
      ST_STANDBY: begin
        if (sleep_enable_bit) begin
          state_next = ST_SLEEP;
        end else if (!standby_enable_bit) begin
          state_next = ST_LISTEN;
        end
      end
      ST_BURST: begin
        if (sleep_enable_bit) begin
          state_next = ST_SLEEP;
        end else if (burst_end) begin
          state_next = standby_enable_bit ? ST_STANDBY : ST_LISTEN;
        end
      end
      default: begin
        if (sleep_enable_bit) begin
          state_next = ST_SLEEP;
        end else if (standby_enable_bit) begin
          state_next = ST_STANDBY;
        end else if (burst_start) begin
          state_next = ST_BURST;
        end else begin
          state_next = ST_LISTEN;
        end
      end
    endcase
  end

  // Power-up behaves like leaving sleep, so reset lands in the wait state.
  // The counter saturates at the limit rather than wrapping, so a supply that
  // never comes up still releases the machine exactly once.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_WAKE;
      wait_reg <= 23'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_WAKE && wait_reg < SUPPLY_WAIT) begin
        wait_reg <= wait_reg + 23'h1;
      end else if (state_reg != ST_WAKE) begin
        wait_reg <= 23'h0;
      end
    end
  end

  // Reported mode; the wake wait still counts as sleep so the code is always valid.
  // Decoded from the present state, so the code never runs ahead of the enables.
  reg [1:0] mode_code;
  always @* begin
    case (state_reg)
      ST_BURST: mode_code = `MODE_BURST;
      ST_STANDBY: mode_code = `MODE_STANDBY;
      ST_LISTEN: mode_code = `MODE_LISTEN;
      default: mode_code = `MODE_SLEEP;
    endcase
  end

  // Block enables registered straight from the mode.
  // Registering them keeps glitches from the state decode off the analog
  // switches. The regulator stays on through the wake wait, since the wait
  // is for that very supply to come up.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      current_mode_code <= `MODE_SLEEP;
      supply_reg_on <= 1'b0;
      analog_on <= 1'b0;
      tx_on <= 1'b0;
      rx_on <= 1'b0;
    end else begin
      current_mode_code <= mode_code;
      supply_reg_on <= (state_reg != ST_SLEEP) && supply_reg_enable;
      analog_on <= (state_reg == ST_LISTEN) || (state_reg == ST_BURST);
      tx_on <= (state_reg == ST_BURST);
      rx_on <= (state_reg == ST_LISTEN) || (state_reg == ST_BURST);
    end
  end

  // Serial shift engine; the chip select idle level holds it in reset.
  // Both sides change their data after a rising serial clock edge and take
  // it at the falling edge. The device therefore shifts sdi in on each
  // falling edge and puts the next response bit out on each rising edge.
  // The response is loaded continuously while chip select is high, so the
  // status it carries is a snapshot taken just before the frame begins.
  // A frame cut short by chip select rising is simply dropped: the bit
  // counter never reaches sixteen, so nothing is written or checked.
  // Bits after the sixteenth are ignored until chip select rises again.
  reg [4:0] bit_cnt_reg;
  reg [15:0] rx_reg;
  reg [15:0] tx_reg;
  reg par_err_reg;
  reg [5:0] last_addr_reg;
  reg cmd_write_reg;

  // The data pin is taken from the same stage as the clock, so a bit that
  // changed at the rising edge has settled long before the falling edge.
  wire [15:0] rx_shift = {rx_reg[14:0], sdi_sync_reg[2]};
  // Fault flags are mirrored as they stand; this block does not latch them,
  // so clearing is left to the fault register that drives them.
  wire [5:0] status = {drive_supply_ok_flag, short_burst_fault, stuck_drive_fault,
                       memory_crc_fault, mode_code};
  // Data byte: echo of the previous address when the previous frame was a write, else read data.
  wire [7:0] resp_data = cmd_write_reg ? {2'h0, last_addr_reg} : rd_data;
  // Parity is computed over the seven upper bits and the data byte, so the
  // whole response frame, parity bit included, has an odd number of ones.
  wire [6:0] resp_hi = {par_err_reg, status};
  wire resp_par = ~(^{resp_hi, resp_data});
  wire [15:0] resp_frame = {par_err_reg, status, resp_par, resp_data};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= 5'h0;
      rx_reg <= 16'h0;
      tx_reg <= 16'h0;
      par_err_reg <= 1'b0;
      last_addr_reg <= 6'h0;
      cmd_write_reg <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= 6'h0;
      wr_data <= 8'h0;
      rd_addr <= 6'h0;
      sdo_o <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      // The write strobe is a pulse: cleared every cycle and set only at the
      // end of a complete write frame with good parity.
      wr_strobe <= 1'b0;
      // Idle: counter cleared and output released until the next frame.
      if (!cs_active) begin
        bit_cnt_reg <= 5'h0;
        sdo_oe <= 1'b0;
        sdo_o <= 1'b0;
        tx_reg <= resp_frame; // Frame loaded while idle.
      end else begin
        // The output is driven for the whole time chip select is low.
        sdo_oe <= 1'b1;
        if (bit_cnt_reg == 5'h0 && sdo_oe == 1'b0) begin
          sdo_o <= tx_reg[15];
        end
        if (sck_fall && bit_cnt_reg < 5'd16) begin
          rx_reg <= rx_shift;
          bit_cnt_reg <= bit_cnt_reg + 5'h1;
          if (bit_cnt_reg == 5'd15) begin
            // Full frame: check odd parity and act on writes.
            // A write with even parity is dropped; the flag goes out next frame.
            par_err_reg <= ~(^rx_shift);
            last_addr_reg <= rx_shift[`ADDR_MSB:`ADDR_LSB];
            cmd_write_reg <= rx_shift[`RW_BIT];
            rd_addr <= rx_shift[`ADDR_MSB:`ADDR_LSB];
            if (^rx_shift && rx_shift[`RW_BIT]) begin
              wr_strobe <= 1'b1;
              wr_addr <= rx_shift[`ADDR_MSB:`ADDR_LSB];
              wr_data <= rx_shift[7:0];
            end
          end
        end
        // Next bit presented after the rising edge, stable by the falling edge.
        // The first rising edge repeats the top bit already shown at chip select.
        if (sck_rise) begin
          tx_reg <= {tx_reg[14:0], 1'b0};
          sdo_o <= tx_reg[15];
        end
      end
    end
  end

  // Echo irq and zero-cross output.
  // The comparator level is synchronised, so the echo irq rises four cycles
  // and falls three cycles after the envelope; a true asynchronous fall would need the
  // pin to act as a reset, which this single-clock design avoids.
  // Gating by the echo irq keeps the zero-cross output quiet between echoes.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      echo_irq_out <= 1'b0;
      zero_cross_out <= 1'b0;
    end else begin
      // Both late stages must agree, so a one-cycle spike on the comparator
      // cannot raise an interrupt.
      echo_irq_out <= env_sync_reg[2] && env_sync_reg[1];
      zero_cross_out <= zero_cross_enable && zero_cross_raw &&
                        (!zero_cross_gate_by_echo || echo_irq_out);
    end
  end

endmodule // serial_control_mode_status

// ===== verif/spi_host.sv
`timescale 1ns/1ns
module spi_host (
  // Pins driven toward the device.
  output logic chip_select_n,
  output logic sclk,
  output logic sdi,
  // Response pins.
  input logic sdo_o,
  input logic sdo_oe
);
  // Deselected with the clock still, as between frames.
  initial begin
    {chip_select_n, sclk, sdi} = 3'h4;
  end
  // One whole frame, MSB first; sdo is read at each falling clock edge.
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    chip_select_n = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      sdi = cmd[i];
      #62 sclk = 1'b0;
      rsp[i] = sdo_oe ? sdo_o : 1'bx;
      #63;
    end
    #100 chip_select_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule // spi_host

// ===== verif/serial_control_mode_status_asserts.sv
`timescale 1ns/1ns
`include "ultra_ctrl_consts.vh"
module serial_control_mode_status_asserts (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Watched ports.
  input wire chip_select_n,
  input wire sdo_oe,
  input wire wr_strobe,
  input wire sleep_enable_bit,
  input wire supply_reg_enable,
  input wire drive_supply_ok_flag,
  input wire envelope_above_thr,
  input wire zero_cross_gate_by_echo,
  input wire tx_on,
  input wire rx_on,
  input wire [1:0] current_mode_code,
  input wire echo_irq_out,
  input wire zero_cross_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Mode sequencing; the wake wait may not end early while the supply is low.
  chk_sleep_wins: assert property (sleep_enable_bit [*4] |-> current_mode_code == `MODE_SLEEP)
    else $error("sleep not taken");
  chk_listen_rx: assert property (current_mode_code == `MODE_LISTEN |-> rx_on && !tx_on)
    else $error("listen enables");
  chk_burst_tx: assert property (current_mode_code == `MODE_BURST |-> rx_on && tx_on)
    else $error("burst enables");
  chk_supply_hold: assert property ($fell(sleep_enable_bit) && supply_reg_enable &&
    !drive_supply_ok_flag |=> (current_mode_code == `MODE_SLEEP) [*8])
    else $error("left sleep early");
  chk_skip_wait: assert property ($fell(sleep_enable_bit) && !supply_reg_enable |->
    ##[1:4] current_mode_code != `MODE_SLEEP)
    else $error("wait not skipped");
  // Link output and echo outputs.
  chk_oe_idle: assert property (chip_select_n [*8] |-> !sdo_oe)
    else $error("sdo driven");
  chk_echo_rise: assert property (envelope_above_thr [*6] |-> echo_irq_out)
    else $error("echo low");
  chk_zc_gate: assert property ((zero_cross_gate_by_echo && !echo_irq_out) [*2] |->
    !zero_cross_out)
    else $error("zero cross ungated");
  cover property (wr_strobe);
  cover property (current_mode_code == `MODE_BURST);
  cover property (zero_cross_out);
endmodule // serial_control_mode_status_asserts

// ===== verif/serial_control_mode_status_test.sv
`timescale 1ns/1ns
`include "ultra_ctrl_consts.vh"
module serial_control_mode_status_test;
  // Every input has a value at time zero.
  logic clk = 0, resetn = 0, sleep_enable_bit = 0, standby_enable_bit = 0, burst_start = 0;
  logic burst_end = 0, supply_reg_enable = 1, drive_supply_ok_flag = 1, short_burst_fault = 0;
  logic stuck_drive_fault = 0, memory_crc_fault = 0, envelope_above_thr = 0, zero_cross_raw = 0;
  logic zero_cross_enable = 0, zero_cross_gate_by_echo = 0;
  wire chip_select_n, sclk, sdi, sdo_o, sdo_oe, wr_strobe, supply_reg_on, analog_on, tx_on, rx_on;
  wire echo_irq_out, zero_cross_out;
  wire [5:0] wr_addr, rd_addr;
  wire [7:0] wr_data, rd_data;
  wire [1:0] current_mode_code;
  logic [15:0] rsp;
  logic [7:0] rows [6] = '{8'h3C, 8'h62, 8'hE7, 8'h93, 8'h6A, 8'h20};
  int miscompares = 0, n_compared = 0, nstb = 0, n;
  // Inverted address as read data, so a stale echo cannot pass for it.
  assign rd_data = {2'h0, ~rd_addr};
  initial forever #5 clk = ~clk;
  always @(posedge clk) nstb <= nstb + wr_strobe;
  serial_control_mode_status #(.SUPPLY_WAIT(23'h32)) dut_u (.clk, .resetn, .chip_select_n, .sclk,
    .sdi, .sdo_o, .sdo_oe, .wr_strobe, .wr_addr, .wr_data, .rd_addr, .rd_data, .sleep_enable_bit,
    .standby_enable_bit, .supply_reg_enable, .burst_start, .burst_end, .drive_supply_ok_flag,
    .short_burst_fault, .stuck_drive_fault, .memory_crc_fault, .supply_reg_on, .analog_on, .tx_on,
    .rx_on, .current_mode_code, .envelope_above_thr, .zero_cross_raw, .zero_cross_enable,
    .zero_cross_gate_by_echo, .echo_irq_out, .zero_cross_out);
  spi_host host_u (.chip_select_n, .sclk, .sdi, .sdo_o, .sdo_oe);
  // Frame with odd parity over all sixteen bits.
  function automatic logic [15:0] mk(input logic b, input logic [5:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {b, a, 1'b0, d};
    f[8] = ~^f;
    return f;
  endfunction
  // Enables {supply, analog, tx, rx} each mode gives with the regulator on.
  function automatic logic [3:0] en_of(input logic [1:0] m);
    case (m)
      `MODE_LISTEN: return 4'hD;
      `MODE_BURST: return 4'hF;
      `MODE_STANDBY: return 4'h8;
      default: return 4'h0;
    endcase
  endfunction
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Bounded wait for a mode, then time for the status to settle.
  task automatic wm(input logic [1:0] m);
    for (int k = 0; k < 8 && current_mode_code !== m; k++) @(negedge clk);
    ck(current_mode_code, m);
    tk(4);
  endtask
  task automatic pulse(ref logic s);
    tk(1);
    s = 1'b1;
    tk(1);
    s = 1'b0;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tk(2);
    ck({current_mode_code, sdo_oe}, 3'h6);
    resetn = 1'b1;
    wm(`MODE_LISTEN);
    host_u.xfer(mk(1'b0, 6'h3F, 8'h00), rsp);
    // Rows: mode and fault inputs, then the status one read frame reports.
    for (int i = 0; i < 6; i++) begin
      tk(1);
      {sleep_enable_bit, standby_enable_bit, drive_supply_ok_flag, short_burst_fault,
        stuck_drive_fault, memory_crc_fault} = rows[i][7:2];
      wm(rows[i][1:0]);
      ck({supply_reg_on, analog_on, tx_on, rx_on}, en_of(rows[i][1:0]));
      host_u.xfer(mk(1'b0, 6'(i), 8'h00), rsp);
      ck(rsp, mk(1'b0, rows[i][5:0], {2'h0, ~6'(i - 1)}));
    end
    // A write, then a bad-parity write that must be dropped and flagged.
    n = nstb;
    host_u.xfer(mk(1'b1, 6'h2A, 8'hC5), rsp);
    ck({wr_addr, wr_data}, {6'h2A, 8'hC5});
    host_u.xfer(mk(1'b1, 6'h01, 8'h55) ^ 16'h0001, rsp);
    ck(rsp[5:0], 6'h2A);
    ck(nstb - n, 1);
    host_u.xfer(mk(1'b0, 6'h05, 8'h00), rsp);
    ck({rsp[15], ^rsp}, 2'h3);
    ck(rd_addr, 6'h05);
    pulse(burst_start);
    wm(`MODE_BURST);
    ck({supply_reg_on, analog_on, tx_on, rx_on}, en_of(`MODE_BURST));
    pulse(burst_end);
    wm(`MODE_LISTEN);
    // Wake with the supply low runs to the timeout; then the level ends it.
    {sleep_enable_bit, drive_supply_ok_flag} = 2'h2;
    wm(`MODE_SLEEP);
    sleep_enable_bit = 1'b0;
    tk(30);
    ck(current_mode_code, `MODE_SLEEP);
    tk(40);
    ck(current_mode_code, `MODE_LISTEN);
    sleep_enable_bit = 1'b1;
    wm(`MODE_SLEEP);
    sleep_enable_bit = 1'b0;
    tk(10);
    drive_supply_ok_flag = 1'b1;
    wm(`MODE_LISTEN);
    {sleep_enable_bit, supply_reg_enable, drive_supply_ok_flag} = 3'h4;
    wm(`MODE_SLEEP);
    sleep_enable_bit = 1'b0;
    wm(`MODE_LISTEN);
    // Zero cross stays off until enabled, then follows the echo gate.
    {zero_cross_enable, zero_cross_gate_by_echo, zero_cross_raw} = 3'h1;
    tk(6);
    ck(zero_cross_out, 1'b0);
    zero_cross_enable = 1'b1;
    tk(6);
    ck(zero_cross_out, 1'b1);
    {zero_cross_enable, zero_cross_gate_by_echo} = 2'h3;
    tk(6);
    ck(zero_cross_out, 1'b0);
    envelope_above_thr = 1'b1;
    tk(6);
    ck({echo_irq_out, zero_cross_out}, 2'h3);
    envelope_above_thr = 1'b0;
    tk(6);
    ck(echo_irq_out, 1'b0);
    resetn = 1'b0;
    tk(1);
    ck({current_mode_code, sdo_oe, wr_strobe}, 4'hC);
    tk(1);
    resetn = 1'b1;
    wm(`MODE_LISTEN);
    host_u.xfer(mk(1'b0, 6'h07, 8'h00), rsp);
    ck({rsp[15], ^rsp}, 2'h1);
    stop_test;
  end
endmodule // serial_control_mode_status_test
bind serial_control_mode_status serial_control_mode_status_asserts chk_u (.clk, .resetn,
  .chip_select_n, .sdo_oe, .wr_strobe, .sleep_enable_bit, .supply_reg_enable,
  .drive_supply_ok_flag, .envelope_above_thr, .zero_cross_gate_by_echo, .tx_on, .rx_on,
  .current_mode_code, .echo_irq_out, .zero_cross_out);
